// ==== core/sadc_top.sv ====
/*
 * register side of the converter control: mode, channel, compare
 * mode, threshold and result registers, pin synchronisers, request.
 * assumes byte or single-bit writes via WMASK on the register port,
 * and a comparator that is high when the held input >= DAC_TAP.
 */
`timescale 1ns/1ps
module sadc_top (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RST,
	// register port
	input  wire logic [15:0] ADDR,
	input  wire logic        WR,
	input  wire logic [7:0]  WMASK,
	input  wire logic [7:0]  WDATA,
	input  wire logic        RD,
	output logic      [7:0]  RDATA,
	// analog front end
	input  wire logic        COMP_IN,
	output logic      [3:0]  CHANNEL_SEL,
	output logic             SAMPLE_HOLD,
	output logic      [7:0]  DAC_TAP,
	// digital use of channels zero to seven
	input  wire logic [7:0]  DIG_PIN,
	output logic      [7:0]  DIG_IN,
	// request
	output logic             CONVERSION_DONE_IRQ
);
	import sadc_pkg::*;

	logic [7:0] converter_mode_reg;
	logic [7:0] next_mode;
	logic [7:0] channel_select_reg;
	logic [7:0] next_channel;
	logic [7:0] compare_mode_reg;
	logic [7:0] next_cmp_mode;
	logic [7:0] compare_threshold_reg;
	logic [7:0] next_threshold;
	logic [7:0] conversion_result_reg;
	logic [7:0] next_result;
	logic       next_irq;
	logic [7:0] next_rdata;
	logic [2:0] comp_sync;
	logic       comp_level;
	logic       next_comp_level;
	logic [7:0] dig_s1;
	logic [7:0] dig_s2;
	logic [7:0] dig_s3;
	logic [7:0] next_dig;
	logic       compare_function_enable;
	logic       compare_polarity_select;
	logic       cond_met;

	sadc_seq_if sq ();

	sadc_seq u_seq (
		.clk (CLK),
		.rst (RST),
		.sq  (sq)
	);

	assign compare_function_enable = compare_mode_reg[CMP_EN_BIT];
	assign compare_polarity_select = compare_mode_reg[CMP_POL_BIT];

	// enable as it will be after this edge, so a stopping write never
	// re-enters sampling and every start has the same latency
	assign sq.run      = next_mode[MODE_RUN_BIT];
	// a mode or channel write aborts, even of equal data, so a stale trial never finishes
	assign sq.restart  = WR && (ADDR == ADDR_MODE ||
		ADDR == ADDR_CHANNEL);
	assign sq.slot_len = sadc_slot_len(
		converter_mode_reg[MODE_TIME_LSB +: 3]);
	// skips the level flop: a 4-cycle slot needs the bit by its last cycle
	assign sq.comp     = next_comp_level;

	assign CHANNEL_SEL = channel_select_reg[3:0];
	assign SAMPLE_HOLD = sq.sampling;
	assign DAC_TAP     = sq.tap;

	// register writes; reserved bits are never stored and read zero
	always_comb begin
		next_mode      = converter_mode_reg;
		next_channel   = channel_select_reg;
		next_cmp_mode  = compare_mode_reg;
		next_threshold = compare_threshold_reg;
		if (WR) begin
			unique case (ADDR)
				ADDR_MODE: next_mode = sadc_merge(converter_mode_reg,
					WDATA, WMASK & MODE_WMASK);
				ADDR_CHANNEL: next_channel = sadc_merge(channel_select_reg,
					WDATA, WMASK & CHANNEL_WMASK);
				ADDR_CMP_MODE: next_cmp_mode = sadc_merge(compare_mode_reg,
					WDATA, WMASK & CMP_WMASK);
				ADDR_THRESHOLD: next_threshold = sadc_merge(
					compare_threshold_reg, WDATA, WMASK);
				default: ;
			endcase
		end
	end

	// result and request; compare sees the new value, not the old one
	always_comb begin
		cond_met = compare_polarity_select ?
			(sq.result < compare_threshold_reg) :
			(sq.result >= compare_threshold_reg);
		next_result = sq.done ? sq.result : conversion_result_reg;
		next_irq    = sq.done &&
			(!compare_function_enable || cond_met);
	end

	always_comb begin
		next_rdata = 8'h00;
		if (RD) begin
			unique case (ADDR)
				ADDR_MODE:      next_rdata = converter_mode_reg;
				ADDR_CHANNEL:   next_rdata = channel_select_reg;
				ADDR_CMP_MODE:  next_rdata = compare_mode_reg;
				ADDR_THRESHOLD: next_rdata = compare_threshold_reg;
				ADDR_RESULT:    next_rdata = conversion_result_reg;
				default:        next_rdata = 8'h00;
			endcase
		end
	end

	// pins: a change counts once second and third stage agree
	always_comb begin
		next_comp_level = (comp_sync[1] == comp_sync[2]) ?
			comp_sync[2] : comp_level;
		for (int i = 0; i < 8; i++) begin
			next_dig[i] = (dig_s2[i] == dig_s3[i]) ? dig_s3[i] : DIG_IN[i];
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			converter_mode_reg    <= REG_RESET;
			channel_select_reg    <= REG_RESET;
			compare_mode_reg      <= REG_RESET;
			compare_threshold_reg <= REG_RESET;
			conversion_result_reg <= REG_RESET;
			CONVERSION_DONE_IRQ   <= 1'b0;
			RDATA                 <= 8'h00;
		end else begin
			converter_mode_reg    <= next_mode;
			channel_select_reg    <= next_channel;
			compare_mode_reg      <= next_cmp_mode;
			compare_threshold_reg <= next_threshold;
			conversion_result_reg <= next_result;
			CONVERSION_DONE_IRQ   <= next_irq;
			RDATA                 <= next_rdata;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			comp_sync  <= 3'h0;
			comp_level <= 1'b0;
			dig_s1     <= 8'h00;
			dig_s2     <= 8'h00;
			dig_s3     <= 8'h00;
			DIG_IN     <= 8'h00;
		end else begin
			comp_sync  <= {comp_sync[1:0], COMP_IN};
			comp_level <= next_comp_level;
			dig_s1     <= DIG_PIN;
			dig_s2     <= dig_s1;
			dig_s3     <= dig_s2;
			DIG_IN     <= next_dig;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	result_load_a: assert property (sq.done |=>
		conversion_result_reg == $past(sq.result))
		else $error("result not loaded at conversion end");
	irq_normal_a: assert property (
		sq.done && !compare_function_enable |=> CONVERSION_DONE_IRQ)
		else $error("missing request after normal conversion");
	irq_compare_a: assert property (sq.done && compare_function_enable |=>
		CONVERSION_DONE_IRQ == ($past(compare_polarity_select) ?
		($past(sq.result) < $past(compare_threshold_reg)) :
		($past(sq.result) >= $past(compare_threshold_reg))))
		else $error("compare request wrong");
	irq_cause_a: assert property (CONVERSION_DONE_IRQ |->
		$past(sq.done))
		else $error("request without conversion end");
	reset_clear_a: assert property (@(posedge CLK) $past(RST) |->
		conversion_result_reg == 8'h00 && converter_mode_reg == 8'h00)
		else $error("registers not cleared by reset");
	channel_sel_a: assert property (WR && ADDR == ADDR_CHANNEL &&
		WMASK == 8'hff && WDATA <= 8'(CHANNEL_LAST) |=>
		CHANNEL_SEL == $past(WDATA[3:0]))
		else $error("channel select not applied");
	bit_write_a: assert property (WR && ADDR == ADDR_MODE &&
		WMASK == 8'h80 |=> converter_mode_reg[6:0] ==
		$past(converter_mode_reg[6:0]))
		else $error("bit write disturbed other mode bits");
	dig_follow_a: assert property (dig_s2 == dig_s3 |=>
		DIG_IN == $past(dig_s3))
		else $error("digital input not following pins");
	cover_compare_irq: cover property (compare_function_enable &&
		CONVERSION_DONE_IRQ);
	cover_fast_time: cover property (sq.done && sq.slot_len == 4'h4);
endmodule

// ==== core/sadc_pkg.sv ====
/*
 * constants, register map and helpers of the 8-bit successive
 * approximation converter control.
 * assumes a 16-bit address, 8-bit data register port on CLK.
 */
package sadc_pkg;
	localparam logic [15:0] ADDR_MODE      = 16'hff98;
	localparam logic [15:0] ADDR_CHANNEL   = 16'hff99;
	localparam logic [15:0] ADDR_CMP_MODE  = 16'hff9a;
	localparam logic [15:0] ADDR_THRESHOLD = 16'hff9b;
	localparam logic [15:0] ADDR_RESULT    = 16'hff9f;
	localparam logic [7:0]  REG_RESET      = 8'h00;
	localparam logic [7:0]  MODE_WMASK     = 8'hb8;
	localparam logic [7:0]  CHANNEL_WMASK  = 8'h0f;
	localparam logic [7:0]  CMP_WMASK      = 8'hc0;
	localparam int          MODE_RUN_BIT   = 7;
	localparam int          MODE_TIME_LSB  = 3;
	localparam int          CMP_EN_BIT     = 7;
	localparam int          CMP_POL_BIT    = 6;
	localparam logic [3:0]  CHANNEL_LAST   = 4'hb;
	localparam logic [3:0]  SAMPLE_SLOTS   = 4'h4;
	localparam logic [3:0]  TOTAL_SLOTS    = 4'hc;
	localparam int          CONV_CYC_0     = 144;
	localparam int          CONV_CYC_1     = 120;
	localparam int          CONV_CYC_2     = 96;
	localparam int          CONV_CYC_4     = 72;
	localparam int          CONV_CYC_5     = 60;
	localparam int          CONV_CYC_6     = 48;

	typedef enum logic [1:0] {SADC_IDLE, SADC_SAMPLE, SADC_CONVERT}
		sadc_state_t;

	// cycles of one of the twelve slots; prohibited codes run slowest
	function automatic logic [3:0] sadc_slot_len(input logic [2:0] code);
		unique case (code)
			3'h1:    sadc_slot_len = 4'(CONV_CYC_1 / 12);
			3'h2:    sadc_slot_len = 4'(CONV_CYC_2 / 12);
			3'h4:    sadc_slot_len = 4'(CONV_CYC_4 / 12);
			3'h5:    sadc_slot_len = 4'(CONV_CYC_5 / 12);
			3'h6:    sadc_slot_len = 4'(CONV_CYC_6 / 12);
			default: sadc_slot_len = 4'(CONV_CYC_0 / 12);
		endcase
	endfunction

	function automatic logic [7:0] sadc_merge(input logic [7:0] old,
		input logic [7:0] data, input logic [7:0] mask);
		sadc_merge = (old & ~mask) | (data & mask);
	endfunction
endpackage

// ==== core/sadc_seq_if.sv ====
/*
 * link between register side and conversion sequencer.
 * assumes both ends on one clock.
 */
`timescale 1ns/1ps
interface sadc_seq_if;
	logic       run;
	logic       restart;
	logic [3:0] slot_len;
	logic       comp;
	logic       done;
	logic [7:0] result;
	logic [7:0] tap;
	logic       sampling;
	modport seq (input run, restart, slot_len, comp,
		output done, result, tap, sampling);
	modport ctl (output run, restart, slot_len, comp,
		input done, result, tap, sampling);
endinterface

// ==== core/sadc_seq.sv ====
/*
 * conversion sequencer: sample slots, then one slot per bit.
 * assumes comp is already synchronised, high when input >= tap.
 */
`timescale 1ns/1ps
module sadc_seq (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control link
	sadc_seq_if.seq  sq
);
	import sadc_pkg::*;

	sadc_state_t state;
	sadc_state_t next_state;
	logic [3:0]  cyc;
	logic [3:0]  next_cyc;
	logic [3:0]  slot;
	logic [3:0]  next_slot;
	logic [7:0]  sar;
	logic [7:0]  next_sar;
	logic [7:0]  len_cnt;
	logic [2:0]  bit_idx;
	logic        slot_end;
	logic [7:0]  decided;

	assign slot_end = (cyc == sq.slot_len - 4'h1);
	assign bit_idx  = 3'(4'hb - slot);
	// trial bit kept only if input reached the tap
	always_comb begin
		decided = sar;
		decided[bit_idx] = sq.comp;
	end

	assign sq.done     = (state == SADC_CONVERT) && slot_end &&
		(slot == TOTAL_SLOTS - 4'h1) && sq.run && !sq.restart;
	assign sq.result   = decided;
	assign sq.tap      = sar;
	assign sq.sampling = (state == SADC_SAMPLE);

	always_comb begin
		next_state = state;
		next_cyc   = slot_end ? 4'h0 : cyc + 4'h1;
		next_slot  = slot_end ? slot + 4'h1 : slot;
		next_sar   = sar;
		if (sq.restart || !sq.run) begin
			next_state = sq.run ? SADC_SAMPLE : SADC_IDLE;
			next_cyc   = 4'h0;
			next_slot  = 4'h0;
			next_sar   = 8'h00;
		end else begin
			unique case (state)
				SADC_IDLE: begin
					next_state = SADC_SAMPLE;
					next_cyc   = 4'h0;
					next_slot  = 4'h0;
				end
				SADC_SAMPLE: begin
					if (slot_end && slot == SAMPLE_SLOTS - 4'h1) begin
						next_state = SADC_CONVERT;
						next_sar   = 8'h80;
					end
				end
				SADC_CONVERT: begin
					if (slot_end) begin
						next_sar = decided;
						if (bit_idx != 3'h0) begin
							next_sar[bit_idx - 3'h1] = 1'b1;
						end
					end
					if (sq.done) begin
						next_state = SADC_SAMPLE;
						next_slot  = 4'h0;
						next_sar   = 8'h00;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= SADC_IDLE;
			cyc   <= 4'h0;
			slot  <= 4'h0;
			sar   <= 8'h00;
		end else begin
			state <= next_state;
			cyc   <= next_cyc;
			slot  <= next_slot;
			sar   <= next_sar;
		end
	end

	// helper: cycles since the current conversion began
	always_ff @(posedge clk) begin
		if (rst || state == SADC_IDLE || sq.restart || sq.done) begin
			len_cnt <= 8'h00;
		end else begin
			len_cnt <= len_cnt + 8'h01;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	conv_length_a: assert property (sq.done |->
		len_cnt == 8'(12 * sq.slot_len - 1))
		else $error("conversion length differs from selected time");
	msb_first_a: assert property (
		(state == SADC_SAMPLE) ##1 (state == SADC_CONVERT) |-> sar == 8'h80)
		else $error("approximation did not start at msb");
	stop_idle_a: assert property (!sq.run |=> state == SADC_IDLE)
		else $error("sequencer kept running while stopped");
	restart_a: assert property (sq.restart && sq.run |=>
		state == SADC_SAMPLE && slot == 4'h0 && cyc == 4'h0)
		else $error("write did not restart conversion");
	cover_full_conv: cover property (sq.done ##[1:200] sq.done);
	cover_abort: cover property ((state == SADC_CONVERT) && sq.restart);
endmodule

// ==== verification/sadc_front_model.sv ====
/*
 * behavioural analog front end: twelve channel levels and comparator.
 * assumes the converter control drives the channel and tap.
 */
`timescale 1ns/1ps
module sadc_front_model (
	// converter side
	input  wire logic [3:0]  channel_sel,
	input  wire logic [7:0]  dac_tap,
	output logic             comp_in,
	// channel n level at bits 8n+7:8n
	input  wire logic [95:0] levels
);
	// ideal comparator; prohibited codes read as a grounded input
	always_comb begin
		if (channel_sel <= 4'hb)
			comp_in = levels[channel_sel*8 +: 8] >= dac_tap;
		else
			comp_in = dac_tap == 8'h00;
	end
endmodule

// ==== verification/sar_adc_control_test.sv ====
/*
 * self-checking bench of the converter control on its register port.
 * assumes the front end model and the CONVERSION_DONE_IRQ pulse.
 */
`timescale 1ns/1ps
module sar_adc_control_test;
	import sadc_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [15:0] addr = 16'h0000;
	logic        wr_s = 1'b0;
	logic        rd_s = 1'b0;
	logic [7:0]  wmask = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic [7:0]  rdata;
	logic        comp;
	logic [3:0]  chan;
	logic        hold;
	logic [7:0]  tap;
	logic [7:0]  dig = 8'ha5;
	logic [7:0]  dig_in;
	logic        irq;
	logic [95:0] levels;
	int          mismatches = 0;
	int          checked = 0;
	int          k0;
	int          n;
	int          d;
	int          cyc[6] = '{CONV_CYC_0, CONV_CYC_1, CONV_CYC_2,
		CONV_CYC_4, CONV_CYC_5, CONV_CYC_6};
	logic [2:0]  codes[6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};

	sadc_top DUT (.CLK(clk), .RST(rst), .ADDR(addr), .WR(wr_s),
		.WMASK(wmask), .WDATA(wdata), .RD(rd_s), .RDATA(rdata),
		.COMP_IN(comp), .CHANNEL_SEL(chan), .SAMPLE_HOLD(hold),
		.DAC_TAP(tap), .DIG_PIN(dig), .DIG_IN(dig_in),
		.CONVERSION_DONE_IRQ(irq));
	sadc_front_model front (.channel_sel(chan), .dac_tap(tap),
		.comp_in(comp), .levels(levels));

	always #50 clk = ~clk;

	task automatic end_of_test();
		if (mismatches == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] v,
		input logic [7:0] m);
		@(posedge clk);
		#1;
		addr = a;
		wdata = v;
		wmask = m;
		wr_s = 1'b1;
		@(posedge clk);
		#1;
		wr_s = 1'b0;
	endtask

	task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		#1;
		addr = a;
		rd_s = 1'b1;
		@(posedge clk);
		#1;
		rd_s = 1'b0;
		chk(rdata, exp);
	endtask

	// counts from the end of the last write, so latencies compare
	task automatic wait_irq(output int k);
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while (irq !== 1'b1 && k < 400);
		if (k >= 400)
			chk(8'h00, 8'h01);
	endtask

	task automatic quiet(input int c);
		repeat (c) begin
			@(posedge clk);
			#1;
			chk({7'h00, irq}, 8'h00);
		end
	endtask

	initial begin
		for (int i = 0; i < 12; i++)
			levels[i*8 +: 8] = 8'(i * 21 + 7);
		repeat (16) @(posedge clk);
		#1;
		rst = 1'b0;
		rchk(ADDR_MODE, REG_RESET);
		rchk(ADDR_CHANNEL, REG_RESET);
		rchk(ADDR_CMP_MODE, REG_RESET);
		rchk(ADDR_THRESHOLD, REG_RESET);
		rchk(ADDR_RESULT, REG_RESET);
		rchk(16'hff9c, 8'h00);
		chk(dig_in, 8'ha5);
		quiet(200);
		for (int j = 0; j < 6; j++) begin
			wr(ADDR_MODE, {2'h2, codes[j], 3'h0}, 8'hff);
			wait_irq(k0);
			wait_irq(n);
			if (j == 0)
				d = k0 - cyc[0];
			chk(8'(n), 8'(cyc[j]));
			chk(8'(k0 - cyc[j]), 8'(d));
			rchk(ADDR_RESULT, levels[7:0]);
		end
		// 144 cycles at 10 MHz keeps each conversion above 14 us
		wr(ADDR_MODE, 8'h80, 8'hff);
		// first result after a restart is already of the new channel; the second is read
		for (int ch = 0; ch < 12; ch++) begin
			wr(ADDR_CHANNEL, 8'(ch), 8'hff);
			wait_irq(n);
			wait_irq(n);
			rchk(ADDR_RESULT, levels[ch*8 +: 8]);
		end
		wr(ADDR_MODE, 8'hb0, 8'hff);
		wr(ADDR_CHANNEL, 8'h05, 8'hff);
		repeat (20) @(posedge clk);
		wr(ADDR_CHANNEL, 8'h05, 8'hff);
		wait_irq(n);
		chk(8'(n), 8'(d + CONV_CYC_6));
		wr(ADDR_THRESHOLD, levels[47:40], 8'hff);
		wr(ADDR_CMP_MODE, 8'h80, 8'hff);
		wait_irq(n);
		wr(ADDR_THRESHOLD, levels[47:40] + 8'h01, 8'hff);
		quiet(150);
		wr(ADDR_CMP_MODE, 8'hc0, 8'hff);
		wait_irq(n);
		wr(ADDR_THRESHOLD, levels[47:40], 8'hff);
		quiet(150);
		wr(ADDR_CMP_MODE, 8'h00, 8'hff);
		wait_irq(n);
		wait_irq(n);
		chk(8'(n), 8'(CONV_CYC_6));
		wr(ADDR_MODE, 8'h00, 8'h80);
		quiet(200);
		chk({7'h00, hold}, 8'h00);
		rchk(ADDR_MODE, 8'h30);
		dig = 8'h3c;
		wr(ADDR_MODE, 8'h80, 8'h80);
		chk({7'h00, hold}, 8'h01);
		wait_irq(k0);
		chk(8'(k0), 8'(d + CONV_CYC_6));
		chk(dig_in, 8'h3c);
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		rchk(ADDR_RESULT, REG_RESET);
		rchk(ADDR_MODE, REG_RESET);
		end_of_test();
	end

	// whole run is a few thousand cycles; this leaves wide margin
	initial begin
		repeat (30000) @(posedge clk);
		mismatches++;
		end_of_test();
	end
endmodule
